/* wdr_pkg.sv */
// Constants, register map and types shared by the watchdog and its counter.
// Assumes a 125 MHz pclk; counts are in CPU clock periods of pclk.
package wdr_pkg;
	// ********************************************************************
	// Register map: printed offsets are word indices, byte address is 4x.
	// ********************************************************************
	localparam logic [15:0] IDX_CTRL = 16'hffae;
	localparam logic [15:0] IDX_CMD = 16'hffb0;
	localparam logic [15:0] IDX_IRQ_STAT = 16'hffb1;
	localparam logic [15:0] IDX_IRQ_CLR = 16'hffb2;
	localparam logic [15:0] IDX_IRQ_EN = 16'hffb3;
	localparam logic [15:0] IDX_CFG = 16'hffb4;
	localparam logic [15:0] IDX_COUNT = 16'hffb5;
	localparam logic [17:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
	localparam logic [17:0] ADDR_CMD = {IDX_CMD, 2'b00};
	localparam logic [17:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
	localparam logic [17:0] ADDR_IRQ_CLR = {IDX_IRQ_CLR, 2'b00};
	localparam logic [17:0] ADDR_IRQ_EN = {IDX_IRQ_EN, 2'b00};
	localparam logic [17:0] ADDR_CFG = {IDX_CFG, 2'b00};
	localparam logic [17:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
	// ********************************************************************
	// Fields and reset values.
	// ********************************************************************
	localparam int F_SEL = 0;
	localparam int F_FLAGS_LO = 1;
	localparam int F_RELOAD_LO = 8;
	localparam int C_SRV = 0;
	localparam int C_END_OF_INIT_INSTR = 1;
	localparam int C_SOFT_RESET_INSTR = 2;
	localparam int C_DIS = 3;
	// Flag vector order is {poweron, long, short, software, timeout}.
	localparam logic [4:0] FLAG_TIMEOUT = 5'h01;
	localparam logic [4:0] PAT_POWERON = 5'h1e;
	localparam logic [4:0] PAT_LONG = 5'h0e;
	localparam logic [4:0] PAT_SHORT = 5'h06;
	localparam logic [4:0] PAT_SOFT = 5'h02;
	localparam logic [4:0] PAT_WDOG = 5'h03;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam int IRQ_OVF = 0;
	localparam int IRQ_PIN = 1;
	localparam int IRQ_DONE = 2;
	// ********************************************************************
	// Timing, counted in TCL (half a CPU clock) and converted to cycles.
	// ********************************************************************
	localparam int TCL_PER_CYCLE = 2;
	localparam int DETECT_TCL = 4;
	localparam int SEQ_TCL = 1024;
	localparam int LONG_TCL = 1040;
	localparam logic [9:0] DETECT_CYCLES = 10'(DETECT_TCL / TCL_PER_CYCLE);
	localparam logic [9:0] SEQ_CYCLES = 10'(SEQ_TCL / TCL_PER_CYCLE);
	localparam logic [9:0] LONG_CYCLES = 10'(LONG_TCL / TCL_PER_CYCLE);
	localparam logic [9:0] SETTLE_CYCLES = 10'h003;
	localparam logic [6:0] PRE_SLOW_LAST = 7'h7f;
	// ********************************************************************
	// Types.
	// ********************************************************************
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_SEQ = 3'b010,
		ST_EXT = 3'b100
	} wdr_state_type;
	typedef enum logic [1:0] {
		SRC_PIN = 2'h0,
		SRC_SOFT = 2'h1,
		SRC_WDOG = 2'h2
	} wdr_src_type;
endpackage

/* wdr_cnt_if.sv */
// Bundle between the watchdog control logic and its counter.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface wdr_cnt_if;
	logic run;
	logic sel128;
	logic service;
	logic restart;
	logic [7:0] reload;
	logic overflow;
	logic [15:0] count;
	modport ctl (output run, output sel128, output service, output restart, output reload,
		input overflow, input count);
	modport cnt (input run, input sel128, input service, input restart, input reload,
		output overflow, output count);
endinterface

/* wdr_counter.sv */
// Prescaler and 16-bit up counter of the watchdog.
// Assumes control inputs come from logic on pclk.
`timescale 1ns/1ps
module wdr_counter import wdr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	wdr_cnt_if.cnt bus
);
	logic [6:0] pre_ff;
	logic [15:0] cnt_ff;
	logic ovf_ff;
	wire tick = bus.run & (bus.sel128 ? (pre_ff == PRE_SLOW_LAST) : pre_ff[0]);
	wire wrap = tick & (cnt_ff == 16'hffff) & ~bus.restart & ~bus.service;

	assign bus.overflow = ovf_ff;
	assign bus.count = cnt_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= 7'h00;
			cnt_ff <= 16'h0000;
			ovf_ff <= 1'b0;
		end else begin
			ovf_ff <= wrap;
			if (bus.restart) begin
				pre_ff <= 7'h00;
				cnt_ff <= 16'h0000;
			end else if (bus.service) begin
				pre_ff <= 7'h00;
				cnt_ff <= {bus.reload, 8'h00};
			end else if (bus.run) begin
				pre_ff <= pre_ff + 7'h01;
				if (tick) begin
					cnt_ff <= cnt_ff + 16'h0001;
				end
			end
		end
	end

	counter_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(cnt_ff) && !$past(bus.service) && !$past(bus.restart)
		|-> cnt_ff == 16'($past(cnt_ff) + 16'h0001))
		else $error("watchdog counter did not step by one");
endmodule

/* wdr_watchdog.sv */
// Watchdog with reset sequencer and reset-source flags, APB slave.
// Assumes APB master on pclk; reset_in_n is an asynchronous open-drain pin.
`timescale 1ns/1ps
module wdr_watchdog import wdr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reset_in_n,
	output logic reset_in_pull_o,
	output logic reset_in_pull_oe,
	output logic reset_out_n,
	output logic hw_reset,
	output logic irq
);
	// ********************************************************************
	// State.
	// ********************************************************************
	wdr_state_type state_ff, nxt_state;
	wdr_src_type src_ff;
	logic [9:0] seq_cnt_ff, low_cnt_ff;
	logic rin_meta_ff, rin_sync_ff;
	logic [4:0] flags_ff, nxt_flags;
	logic [7:0] reload_ff;
	logic sel_ff, run_ff, init_done_ff, bidir_ff, bidir_seq_ff, esc_ff;
	logic [2:0] irq_stat_ff, irq_en_ff, nxt_irq_stat;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff, pull_o_ff, pull_oe_ff, reset_out_n_ff, hw_reset_ff, irq_ff;
	wdr_cnt_if cnt_bus ();

	// ********************************************************************
	// APB decode.
	// ********************************************************************
	wire setup = psel & ~penable;
	wire wr = psel & penable & pready_ff & pwrite;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_cmd = paddr == ADDR_CMD;
	wire hit_stat = paddr == ADDR_IRQ_STAT;
	wire hit_clr = paddr == ADDR_IRQ_CLR;
	wire hit_en = paddr == ADDR_IRQ_EN;
	wire hit_cfg = paddr == ADDR_CFG;
	wire hit_cnt = paddr == ADDR_COUNT;
	wire mapped = hit_ctrl | hit_cmd | hit_stat | hit_clr | hit_en | hit_cfg | hit_cnt;
	wire in_run = state_ff == ST_RUN;
	wire in_seq = state_ff == ST_SEQ;
	wire in_ext = state_ff == ST_EXT;
	// Commands are dropped while the sequencer holds the chip in reset.
	wire wr_ctrl = wr & hit_ctrl & in_run;
	wire wr_cmd = wr & hit_cmd & in_run;
	wire srv_do = wr_cmd & pwdata[C_SRV];
	wire end_of_init_instr_do = wr_cmd & pwdata[C_END_OF_INIT_INSTR] & ~init_done_ff;
	wire soft_reset_instr_do = wr_cmd & pwdata[C_SOFT_RESET_INSTR];
	wire dis_do = wr_cmd & pwdata[C_DIS] & ~init_done_ff;
	wire [2:0] clr_mask = (wr & hit_clr) ? pwdata[2:0] : 3'h0;
	wire [31:0] rd_ctrl = {16'h0000, reload_ff, 2'b00, flags_ff, sel_ff};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_stat ? {29'h0, irq_stat_ff} :
		hit_en ? {29'h0, irq_en_ff} :
		hit_cfg ? {31'h0, bidir_ff} :
		hit_cnt ? {16'h0000, cnt_bus.count} : 32'h0000_0000;

	// ********************************************************************
	// Reset sources and sequencer.
	// ********************************************************************
	wire pin_low = ~rin_sync_ff;
	wire pin_hit = in_run & pin_low & (low_cnt_ff == DETECT_CYCLES - 10'h001);
	wire ovf_hit = in_run & cnt_bus.overflow;
	wire start = pin_hit | ovf_hit | (in_run & soft_reset_instr_do);
	wire seq_end = in_seq & (seq_cnt_ff == SEQ_CYCLES - 10'h001);
	wire settled = in_ext & (seq_cnt_ff >= SETTLE_CYCLES);
	wire esc_now = settled & pin_low & bidir_seq_ff;
	wire fin = settled & ~pin_low;
	// Our own pull-down must not be mistaken for a long external pulse.
	wire low_count_en = pin_low & ~pull_oe_ff & (low_cnt_ff < LONG_CYCLES);
	wire [4:0] pin_pat = (low_cnt_ff >= LONG_CYCLES) ? PAT_LONG : PAT_SHORT;
	wire [4:0] fin_pat = esc_ff ? PAT_LONG :
		(src_ff == SRC_PIN) ? pin_pat :
		(src_ff == SRC_WDOG) ? PAT_WDOG : PAT_SOFT;
	wire hw_kind = esc_ff | (src_ff == SRC_PIN);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_RUN: begin
				if (start) begin
					nxt_state = ST_SEQ;
				end
			end
			ST_SEQ: begin
				if (seq_end) begin
					nxt_state = ST_EXT;
				end
			end
			ST_EXT: begin
				if (fin) begin
					nxt_state = ST_RUN;
				end
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	// Flags change only on a finished sequence, end of init or a service.
	always_comb begin
		nxt_flags = flags_ff;
		if (fin) begin
			nxt_flags = (hw_kind ? (flags_ff & ~FLAG_TIMEOUT) : flags_ff) | fin_pat;
		end else if (end_of_init_instr_do) begin
			nxt_flags = 5'h00;
		end else if (srv_do) begin
			nxt_flags = flags_ff & ~FLAG_TIMEOUT;
		end
	end

	always_comb begin
		nxt_irq_stat = irq_stat_ff & ~clr_mask;
		nxt_irq_stat[IRQ_OVF] = nxt_irq_stat[IRQ_OVF] | ovf_hit;
		nxt_irq_stat[IRQ_PIN] = nxt_irq_stat[IRQ_PIN] | pin_hit;
		nxt_irq_stat[IRQ_DONE] = nxt_irq_stat[IRQ_DONE] | fin;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rin_meta_ff <= 1'b1;
			rin_sync_ff <= 1'b1;
		end else begin
			rin_meta_ff <= reset_in_n;
			rin_sync_ff <= rin_meta_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_RUN;
			src_ff <= SRC_PIN;
			seq_cnt_ff <= 10'h000;
			esc_ff <= 1'b0;
			bidir_seq_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (start) begin
				src_ff <= pin_hit ? SRC_PIN : (ovf_hit ? SRC_WDOG : SRC_SOFT);
				bidir_seq_ff <= bidir_ff;
				esc_ff <= 1'b0;
			end else if (esc_now) begin
				esc_ff <= 1'b1;
			end
			if (start | seq_end) begin
				seq_cnt_ff <= 10'h000;
			end else if (in_seq | (in_ext & ~settled)) begin
				seq_cnt_ff <= seq_cnt_ff + 10'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_ff <= 10'h000;
		end else if ((in_run & ~pin_low) | (start & ~pin_hit)) begin
			low_cnt_ff <= 10'h000;
		end else if (low_count_en) begin
			low_cnt_ff <= low_cnt_ff + 10'h001;
		end
	end

	// ********************************************************************
	// Control register and watchdog enable.
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= PAT_POWERON;
			reload_ff <= RELOAD_RST;
			sel_ff <= 1'b0;
			run_ff <= 1'b1;
			init_done_ff <= 1'b0;
			bidir_ff <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			if (start) begin
				reload_ff <= RELOAD_RST;
				sel_ff <= 1'b0;
				run_ff <= 1'b1;
				init_done_ff <= 1'b0;
				bidir_ff <= 1'b0;
			end else begin
				if (wr_ctrl) begin
					reload_ff <= pwdata[F_RELOAD_LO +: 8];
					sel_ff <= pwdata[F_SEL];
				end
				if (dis_do) begin
					run_ff <= 1'b0;
				end
				if (end_of_init_instr_do) begin
					init_done_ff <= 1'b1;
				end
				if (wr & hit_cfg & in_run) begin
					bidir_ff <= pwdata[0];
				end
			end
		end
	end

	assign cnt_bus.run = run_ff;
	assign cnt_bus.sel128 = sel_ff;
	assign cnt_bus.service = srv_do;
	assign cnt_bus.restart = ~in_run;
	assign cnt_bus.reload = reload_ff;

	wdr_counter u_counter (
		.pclk(pclk),
		.presetn(presetn),
		.bus(cnt_bus)
	);

	// ********************************************************************
	// Bus answer, pins and interrupt.
	// ********************************************************************
	// No wait state: prdata and pslverr are registered in the setup cycle and come straight from flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~mapped;
			if (setup) begin
				prdata_ff <= (pwrite | ~mapped) ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pull_o_ff <= 1'b0;
			pull_oe_ff <= 1'b0;
			reset_out_n_ff <= 1'b0;
			hw_reset_ff <= 1'b1;
			irq_stat_ff <= 3'h0;
			irq_en_ff <= 3'h0;
			irq_ff <= 1'b0;
		end else begin
			pull_o_ff <= 1'b0;
			pull_oe_ff <= (nxt_state == ST_SEQ) & (start ? bidir_ff : bidir_seq_ff);
			reset_out_n_ff <= nxt_state == ST_RUN;
			hw_reset_ff <= nxt_state != ST_RUN;
			irq_stat_ff <= nxt_irq_stat;
			if (wr & hit_en) begin
				irq_en_ff <= pwdata[2:0];
			end
			irq_ff <= |(irq_stat_ff & irq_en_ff);
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign reset_in_pull_o = pull_o_ff;
	assign reset_in_pull_oe = pull_oe_ff;
	assign reset_out_n = reset_out_n_ff;
	assign hw_reset = hw_reset_ff;
	assign irq = irq_ff;

	// ********************************************************************
	// Checks.
	// ********************************************************************
	logic [23:0] age_ff, exp_ff;
	logic age_ok_ff;
	logic [9:0] low_len_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_len_ff <= 10'h000;
		end else if (in_run) begin
			low_len_ff <= 10'h000;
		end else if (low_len_ff != 10'h3ff) begin
			low_len_ff <= low_len_ff + 10'h001;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_ff <= 24'h000000;
			exp_ff <= 24'h000000;
			age_ok_ff <= 1'b0;
		end else if (srv_do) begin
			age_ff <= 24'h000000;
			exp_ff <= (sel_ff ? 24'h008000 : 24'h000200) * {16'h0000, 8'(8'hff - reload_ff)}
				+ (sel_ff ? 24'h008000 : 24'h000200);
			age_ok_ff <= run_ff;
		end else begin
			age_ff <= age_ff + 24'h000001;
			if (wr_ctrl | ~run_ff | ~in_run) begin
				age_ok_ff <= 1'b0;
			end
		end
	end

	run_after_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(reset_out_n) |-> run_ff && !init_done_ff)
		else $error("watchdog not running after reset sequence");
	disable_late_a: assert property (@(posedge pclk) disable iff (!presetn)
		init_done_ff && run_ff && !start |=> run_ff)
		else $error("watchdog disabled after end of init");
	ovf_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		ovf_hit |=> !reset_out_n && hw_reset ##1 !reset_out_n[*8])
		else $error("overflow did not drive reset");
	timeout_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_bus.overflow && age_ok_ff |-> age_ff == exp_ff)
		else $error("watchdog timeout length wrong");
	wdt_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		fin && src_ff == SRC_WDOG && !esc_ff |=> flags_ff[0] && flags_ff[1])
		else $error("watchdog reset flags not set");
	srv_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		srv_do && !fin |=> !flags_ff[0] && cnt_bus.count[7:0] == 8'h00)
		else $error("service did not clear timeout flag");
	end_of_init_instr_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		end_of_init_instr_do && !fin |=> flags_ff == 5'h00)
		else $error("end of init left flags set");
	flags_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(flags_ff) |-> $past(fin) || $past(end_of_init_instr_do) || $past(srv_do))
		else $error("reset flags changed without cause");
	escalate_a: assert property (@(posedge pclk) disable iff (!presetn)
		fin && esc_ff |=> flags_ff[3:1] == 3'h7)
		else $error("escalated reset not reported long");
	pin_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		fin && src_ff == SRC_PIN |=> flags_ff[2] && flags_ff[1] && !flags_ff[0])
		else $error("pin reset flags wrong");
	seq_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(in_run) |-> reset_out_n && low_len_ff >= SEQ_CYCLES + SETTLE_CYCLES + 10'h001)
		else $error("reset sequence too short");

	cov_ovf_c: cover property (@(posedge pclk) disable iff (!presetn) ovf_hit);
	cov_esc_c: cover property (@(posedge pclk) disable iff (!presetn) fin && esc_ff);
	cov_end_of_init_instr_c: cover property (@(posedge pclk) disable iff (!presetn) end_of_init_instr_do);
	cov_soft_c: cover property (@(posedge pclk) disable iff (!presetn) fin && src_ff == SRC_SOFT);
endmodule

/* tb_top.sv */
// Self-checking testbench for the watchdog with reset-source flags.
// Assumes wdr_pkg and the design files are compiled first; the bench drives every port.
`timescale 1ns/1ps
module tb_top import wdr_pkg::*; ;
	// ********************************************************************
	// Clock, reset and pins.
	// ********************************************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin_low = 1'b0;
	logic reset_in_n;
	logic reset_in_pull_o;
	logic reset_in_pull_oe;
	logic reset_out_n;
	logic hw_reset;
	logic irq;
	int checks = 0;
	int miscompares = 0;
	int cyc = 0;
	int last_cyc;
	// The pin is open drain: low when the bench or the block pulls it.
	assign reset_in_n = !(pin_low || (reset_in_pull_oe && !reset_in_pull_o));
	always #4 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	wdr_watchdog DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reset_in_n(reset_in_n), .reset_in_pull_o(reset_in_pull_o),
		.reset_in_pull_oe(reset_in_pull_oe), .reset_out_n(reset_out_n),
		.hw_reset(hw_reset), .irq(irq));
	// ********************************************************************
	// Shared tasks.
	// ********************************************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic hang(input string what);
		miscompares++;
		$display("MISMATCH %s expected completion seen timeout", what);
		end_sim();
	endtask
	task automatic apb(input logic wr, input logic [17:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			hang("apb answer");
		end
		rdata = prdata;
		err = pslverr;
		last_cyc = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [17:0] addr, input logic [31:0] data);
		logic [31:0] r;
		logic e;
		apb(1'b1, addr, data, r, e);
	endtask
	task automatic rd(input logic [17:0] addr, output logic [31:0] data);
		logic e;
		apb(1'b0, addr, 32'h0, data, e);
	endtask
	// Counts edges until the reset output shows the given level.
	task automatic wait_out(input logic level, input int limit, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (reset_out_n !== level && n < limit);
		if (reset_out_n !== level) begin
			hang("reset output level");
		end
	endtask
	task automatic chk_flags(input string name, input logic [4:0] exp);
		logic [31:0] r;
		rd(ADDR_CTRL, r);
		chk(name, {27'h0, r[5:1]}, {27'h0, exp});
	endtask
	// ********************************************************************
	// Scenarios.
	// ********************************************************************
	task automatic t_reset_regs();
		logic [31:0] r;
		logic [31:0] c;
		logic e;
		chk("reset out", {31'h0, reset_out_n}, 32'h1);
		rd(ADDR_CTRL, r);
		chk("ctrl reset", r, 32'h0000003c);
		apb(1'b0, 18'h00000, 32'h0, r, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		wr(ADDR_CTRL, 32'h0000ff3e);
		rd(ADDR_CTRL, r);
		chk("flags kept", r, 32'h0000ff3c);
		wr(ADDR_CMD, 32'h1 << C_END_OF_INIT_INSTR);
		rd(ADDR_CTRL, r);
		chk("flags cleared", r, 32'h0000ff00);
		wr(ADDR_CMD, 32'h1 << C_DIS);
		rd(ADDR_COUNT, r);
		rd(ADDR_COUNT, c);
		chk("late disable", {31'h0, c != r}, 32'h1);
		$display("register test done");
	endtask
	task automatic t_pin_short();
		logic [31:0] r;
		int n;
		pin_low <= 1'b1;
		repeat (10) @(posedge pclk);
		pin_low <= 1'b0;
		wait_out(1'b0, 20, n);
		wait_out(1'b1, 1500, n);
		chk_flags("short flags", PAT_SHORT);
		rd(ADDR_IRQ_STAT, r);
		chk("pin event", r & 32'h2, 32'h2);
		$display("short pin reset test done");
	endtask
	task automatic t_count(input logic sel, input int gap, input int div);
		logic [31:0] a;
		logic [31:0] b;
		int c1;
		int d;
		int x;
		wr(ADDR_CTRL, {16'h0, 8'hff, 7'h0, sel});
		wr(ADDR_CMD, 32'h1 << C_SRV);
		rd(ADDR_COUNT, a);
		c1 = last_cyc;
		repeat (gap) @(posedge pclk);
		rd(ADDR_COUNT, b);
		d = int'(b[15:0] - a[15:0]);
		x = (last_cyc - c1) / div;
		chk("count step", 32'(d >= x - 1 && d <= x + 1), 32'h1);
		chk("high byte", {24'h0, a[15:8]}, 32'h000000ff);
		$display("count test done, select %0d", sel);
	endtask
	task automatic t_timeout();
		int n;
		wr(ADDR_IRQ_EN, 32'h1 << IRQ_OVF);
		wr(ADDR_CTRL, 32'h0000ff00);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(ADDR_CMD, 32'h1 << C_SRV);
		wait_out(1'b0, 600, n);
		chk("timeout cycles", n, 513);
		chk("internal reset", {31'h0, hw_reset}, 32'h1);
		wait_out(1'b1, 2000, n);
		chk("reset length", 32'(n >= 515), 32'h1);
		chk("internal reset end", {31'h0, hw_reset}, 32'h0);
		chk_flags("timeout flags", PAT_SHORT | PAT_WDOG);
		chk("irq raised", {31'h0, irq}, 32'h1);
		wr(ADDR_IRQ_CLR, 32'h1 << IRQ_OVF);
		repeat (2) @(posedge pclk);
		#1;
		chk("irq cleared", {31'h0, irq}, 32'h0);
		wr(ADDR_CMD, 32'h1 << C_SRV);
		chk_flags("service clears", PAT_SHORT);
		$display("timeout test done");
	endtask
	task automatic t_escalate();
		logic [31:0] r;
		logic [31:0] s;
		int n;
		wr(ADDR_CFG, 32'h1);
		wr(ADDR_CMD, 32'h1 << C_SOFT_RESET_INSTR);
		wait_out(1'b0, 20, n);
		@(posedge pclk);
		pin_low <= 1'b1;
		repeat (4) @(posedge pclk);
		#1;
		chk("bidir pull", {31'h0, reset_in_pull_oe}, 32'h1);
		chk("pull value", {31'h0, reset_in_pull_o}, 32'h0);
		repeat (600) @(posedge pclk);
		pin_low <= 1'b0;
		wait_out(1'b1, 100, n);
		chk_flags("long flags", PAT_LONG);
		rd(ADDR_CFG, r);
		chk("bidir cleared", r, 32'h0);
		wr(ADDR_CMD, 32'h1 << C_DIS);
		rd(ADDR_COUNT, r);
		repeat (20) @(posedge pclk);
		rd(ADDR_COUNT, s);
		chk("early disable", s, r);
		$display("escalation test done");
	endtask
	// ********************************************************************
	// Main sequence.
	// ********************************************************************
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		t_reset_regs();
		t_pin_short();
		t_count(1'b0, 200, 2);
		t_count(1'b1, 600, 128);
		t_timeout();
		t_escalate();
		end_sim();
	end
	// A hang anywhere still reaches the closing report.
	initial begin
		#400000;
		hang("whole run");
	end
endmodule
